// File: inc/edcr_defs.svh
// Functional notes
// R1: Acoustic enhancement threshold bits 15-14, 24/18/30 dB.
// R2: Acoustic noise threshold bits 13-12: zero/-42/-54 dB.
// R3: Noise above threshold: acoustic enhancement must reach it.
// R4: Zero noise threshold: enhancement only; else estimate.
// R5: Network enhancement threshold bits 11-10, 24/18/30 dB.
// R6: Network noise threshold bits 9-8: zero/-42/-54 dB.
// R7: Far noise above threshold: network enhancement decides.
// R8: Zero network noise threshold: enhancement always decides.
// R9: Nonzero network threshold: no path disables canceller.
// R10: Host sets nonzero network threshold when path unknown.
// R11: Receive gain bits 7-6: 0/6/9.5/12 dB.
// R12: Transmit gain bits 5-4: 0/6/9.5/12 dB.
// R13: Instability event clears both canceller coefficient sets.
// R14: Bit 15 disables howl detector clearing.
// R15: Bits 14-12 disable tone and path-change detectors.
// R16: Bits 11-10 disable the pre-emphasis filters.
// R17: Bits 9-8 disable acoustic and network cancellers.
// R18: Sidetone fields 7-6, 5-4: none/-24/-18/-12 dB.
// R19: Tone: half-duplex clears and forces receive; else freezes.
// R20: Enabled path-change detectors clear their own coefficients.
// R21: Disabled canceller leaves path and duplex decision.
// R22: Low four bits select register; only match updates.
`ifndef EDCR_DEFS_SVH
`define EDCR_DEFS_SVH
`define EDCR_ADDR_THR      4'h4
`define EDCR_ADDR_DET      4'h5
`define EDCR_CODE_THR      4'h8
`define EDCR_CODE_DET      4'hA
`define EDCR_RST_THR       16'h0008
`define EDCR_RST_DET       16'h000A
`define EDCR_ACOUSTIC_ENHANCEMENT_THRESHOLD_LSB     14
`define EDCR_ACOUSTIC_NOISE_THRESHOLD_LSB     12
`define EDCR_NETWORK_ENHANCEMENT_THRESHOLD_LSB     10
`define EDCR_NETWORK_NOISE_THRESHOLD_LSB     8
`define EDCR_RECEIVE_GAIN_SELECT_LSB     6
`define EDCR_TRANSMIT_GAIN_SELECT_LSB     4
`define EDCR_HOWL_BIT      15
`define EDCR_TONE_BIT      14
`define EDCR_APC_BIT       13
`define EDCR_NPC_BIT       12
`define EDCR_APF_BIT       11
`define EDCR_NPF_BIT       10
`define EDCR_AEC_BIT       9
`define EDCR_NEC_BIT       8
`define EDCR_ACOUSTIC_SIDETONE_LEVEL_LSB      6
`define EDCR_NETWORK_SIDETONE_LEVEL_LSB      4
`define EDCR_ERLE_DB_00    8'h18
`define EDCR_ERLE_DB_01    8'h12
`define EDCR_ERLE_DB_10    8'h1E
`define EDCR_NOISE_DB_01   8'h2A
`define EDCR_NOISE_DB_10   8'h36
`endif

// File: inc/edcr_pkg.sv
package edcr_pkg;
  // Whole state of the control bank, registered in one process.
  typedef struct packed {
    logic [15:0] thr;       // Threshold and gain register.
    logic [15:0] det;       // Detector disable and sidetone register.
    logic [15:0] rdata;     // Read data, valid one cycle after a read.
    logic        clr_a;     // Clear acoustic coefficients pulse.
    logic        clr_n;     // Clear network coefficients pulse.
    logic        frz_a;     // Freeze acoustic coefficients pulse.
    logic        force_rx;  // Force receive mode pulse.
    logic        fd_allow;  // Full-duplex permitted.
  } edcr_state_t;
endpackage : edcr_pkg

// File: rtl/edcr_regs.sv
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "edcr_defs.svh"

module edcr_regs (
  input  wire logic        clk_sys,         // System clock, 20 MHz.
  input  wire logic        rst,             // Async reset, active high.
  input  wire logic [3:0]  reg_addr,        // Register address.
  input  wire logic [15:0] reg_wdata,       // Control word to write.
  input  wire logic        reg_wr,          // Write strobe.
  input  wire logic        reg_rd,          // Read strobe.
  output logic      [15:0] reg_rdata,       // Read data, next cycle.
  input  wire logic [7:0]  acoustic_erle,   // Measured acoustic dB.
  input  wire logic [7:0]  network_erle,    // Measured network dB.
  input  wire logic [7:0]  near_noise,      // Near noise, dB below FS.
  input  wire logic [7:0]  far_noise,       // Far noise, dB below FS.
  input  wire logic        acoustic_asym_ok, // Acoustic estimate ok.
  input  wire logic        network_asym_ok, // Network estimate ok.
  input  wire logic        network_path_seen, // Coupling path found.
  input  wire logic        in_full_duplex,  // Engine in full-duplex.
  input  wire logic        howl_event,      // Instability pulse.
  input  wire logic        tone_event,      // Receive tone pulse.
  input  wire logic        acoustic_pc_event, // Acoustic path change.
  input  wire logic        network_pc_event, // Network path change.
  output logic             full_duplex_allow, // Duplex permitted.
  output logic             clear_acoustic_coef, // Clear pulse.
  output logic             clear_network_coef, // Clear pulse.
  output logic             freeze_acoustic_coef, // Freeze pulse.
  output logic             force_receive,   // Force receive pulse.
  output logic             acoustic_echo_canceller, // Canceller on.
  output logic             network_echo_canceller, // Canceller on.
  output logic             acoustic_preemphasis_on, // Filter on.
  output logic             network_preemphasis_on, // Filter on.
  output logic      [1:0]  receive_gain_select, // Receive gain.
  output logic      [1:0]  transmit_gain_select, // Transmit gain.
  output logic      [1:0]  acoustic_sidetone_level, // Sidetone.
  output logic      [1:0]  network_sidetone_level // Sidetone.
);

  // Current and next copy of the whole state.
  edcr_pkg::edcr_state_t st;
  edcr_pkg::edcr_state_t next_st;

  // Field views of the threshold register.
  logic [1:0] acoustic_enhancement_threshold; // Acoustic code.
  logic [1:0] acoustic_noise_threshold;       // Acoustic noise code.
  logic [1:0] network_enhancement_threshold;  // Network code.
  logic [1:0] network_noise_threshold;        // Network noise code.

  // Field views of the detector register.
  logic howl_detect_off;          // Howl detector disabled.
  logic tone_detect_off;          // Tone detector disabled.
  logic acoustic_path_change_off; // Acoustic detector disabled.
  logic network_path_change_off;  // Network detector disabled.
  logic acoustic_preemphasis_off; // Acoustic filter disabled.
  logic network_preemphasis_off;  // Network filter disabled.
  logic acoustic_canceller_off;   // Acoustic canceller disabled.
  logic network_canceller_off;    // Network canceller disabled.

  // Decision terms.
  logic [7:0] acoustic_erle_db;   // Decoded acoustic threshold.
  logic [7:0] network_erle_db;    // Decoded network threshold.
  logic [7:0] acoustic_noise_db;  // Decoded acoustic noise level.
  logic [7:0] network_noise_db;   // Decoded network noise level.
  logic       acoustic_ok;        // Acoustic side permits duplex.
  logic       network_ok;         // Network side permits duplex.
  logic       network_auto_off;   // Network canceller auto-disabled.
  logic       acoustic_active;    // Acoustic canceller in use.
  logic       network_active;     // Network canceller in use.
  logic       wr_thr;             // Accepted write to threshold reg.
  logic       wr_det;             // Accepted write to detector reg.

  // Reserved code 11 falls back to the reset threshold, so a stray
  // host write cannot leave the decision with no criterion.
  function automatic logic [7:0] edcr_erle_db(input logic [1:0] code);
    logic [7:0] db;
    db = `EDCR_ERLE_DB_00;
    if (code == 2'h1) begin
      db = `EDCR_ERLE_DB_01;
    end else if (code == 2'h2) begin
      db = `EDCR_ERLE_DB_10;
    end
    return db;
  endfunction : edcr_erle_db

  // Zero means no noise threshold; reserved code reads as zero too.
  function automatic logic [7:0] edcr_noise_db(input logic [1:0] code);
    logic [7:0] db;
    db = 8'h00;
    if (code == 2'h1) begin
      db = `EDCR_NOISE_DB_01;
    end else if (code == 2'h2) begin
      db = `EDCR_NOISE_DB_10;
    end
    return db;
  endfunction : edcr_noise_db

  // Split the registers into their named fields.
  always_comb begin
    acoustic_enhancement_threshold =
      st.thr[`EDCR_ACOUSTIC_ENHANCEMENT_THRESHOLD_LSB+1:`EDCR_ACOUSTIC_ENHANCEMENT_THRESHOLD_LSB]; // see R1
    acoustic_noise_threshold =
      st.thr[`EDCR_ACOUSTIC_NOISE_THRESHOLD_LSB+1:`EDCR_ACOUSTIC_NOISE_THRESHOLD_LSB]; // see R2
    network_enhancement_threshold =
      st.thr[`EDCR_NETWORK_ENHANCEMENT_THRESHOLD_LSB+1:`EDCR_NETWORK_ENHANCEMENT_THRESHOLD_LSB]; // see R5
    network_noise_threshold =
      st.thr[`EDCR_NETWORK_NOISE_THRESHOLD_LSB+1:`EDCR_NETWORK_NOISE_THRESHOLD_LSB]; // see R6
    howl_detect_off          = st.det[`EDCR_HOWL_BIT]; // see R14
    tone_detect_off          = st.det[`EDCR_TONE_BIT]; // see R15
    acoustic_path_change_off = st.det[`EDCR_APC_BIT];  // see R15
    network_path_change_off  = st.det[`EDCR_NPC_BIT];  // see R15
    acoustic_preemphasis_off = st.det[`EDCR_APF_BIT];  // see R16
    network_preemphasis_off  = st.det[`EDCR_NPF_BIT];  // see R16
    acoustic_canceller_off   = st.det[`EDCR_AEC_BIT];  // see R17
    network_canceller_off    = st.det[`EDCR_NEC_BIT];  // see R17
  end

  // Full-duplex criteria for each canceller.
  // Noise levels are attenuations below full scale, so a level that
  // exceeds the threshold is a smaller attenuation number.
  always_comb begin
    acoustic_erle_db  = edcr_erle_db(acoustic_enhancement_threshold);
    network_erle_db   = edcr_erle_db(network_enhancement_threshold);
    acoustic_noise_db = edcr_noise_db(acoustic_noise_threshold);
    network_noise_db  = edcr_noise_db(network_noise_threshold);
    // Zero threshold: enhancement alone decides.
    if (acoustic_noise_db == 8'h00) begin
      acoustic_ok = (acoustic_erle > acoustic_erle_db); // see R4
    end else if (near_noise < acoustic_noise_db) begin
      acoustic_ok = (acoustic_erle >= acoustic_erle_db); // see R3
    end else begin
      acoustic_ok = acoustic_asym_ok; // see R4
    end
    // Network side follows the same pattern, but a noisy input needs more than the threshold.
    if (network_noise_db == 8'h00) begin
      network_ok = (network_erle > network_erle_db); // see R8
    end else if (far_noise < network_noise_db) begin
      network_ok = (network_erle > network_erle_db); // see R7
    end else begin
      network_ok = network_asym_ok; // see R7
    end
    // With a nonzero network threshold a missing path retires the
    // network canceller; the host relies on this when unsure.
    network_auto_off = (network_noise_db != 8'h00) &&
                       !network_path_seen; // see R9 R10
    acoustic_active  = !acoustic_canceller_off; // see R17
    network_active   = !network_canceller_off &&
                       !network_auto_off; // see R17 R9
  end

  // Bus decode: a write lands only when both the address and the
  // select code in the low nibble agree, so a misrouted word from
  // the host cannot corrupt the other register.
  always_comb begin
    wr_thr = 1'b0;
    wr_det = 1'b0;
    if (reg_wr && reg_addr == `EDCR_ADDR_THR) begin
      wr_thr = (reg_wdata[3:0] == `EDCR_CODE_THR); // see R22
    end else if (reg_wr && reg_addr == `EDCR_ADDR_DET) begin
      wr_det = (reg_wdata[3:0] == `EDCR_CODE_DET); // see R22
    end
  end

  // Next-state logic for registers, read data and event pulses.
  always_comb begin
    next_st = st;
    // Select codes are kept in the low nibble so reads echo them.
    if (wr_thr) begin
      next_st.thr = reg_wdata; // see R22
    end
    if (wr_det) begin
      next_st.det = reg_wdata; // see R22
    end
    // Read data stand for one cycle only; unmapped reads give zero.
    next_st.rdata = 16'h0000;
    if (reg_rd && reg_addr == `EDCR_ADDR_THR) begin
      next_st.rdata = st.thr;
    end else if (reg_rd && reg_addr == `EDCR_ADDR_DET) begin
      next_st.rdata = st.det;
    end
    // Coefficient control pulses default low each cycle.
    next_st.clr_a    = 1'b0;
    next_st.clr_n    = 1'b0;
    next_st.frz_a    = 1'b0;
    next_st.force_rx = 1'b0;
    // Instability clears both sets unless the detector is off.
    if (howl_event && !howl_detect_off) begin
      next_st.clr_a = 1'b1; // see R13 R14
      next_st.clr_n = 1'b1; // see R13 R14
    end
    // Tone handling depends on the current duplex mode.
    if (tone_event && !tone_detect_off) begin
      if (in_full_duplex) begin
        next_st.frz_a = 1'b1; // see R19
      end else begin
        next_st.clr_a    = 1'b1; // see R19
        next_st.force_rx = 1'b1; // see R19
      end
    end
    // Path-change detectors each clear their own canceller.
    if (acoustic_pc_event && !acoustic_path_change_off) begin
      next_st.clr_a = 1'b1; // see R20
    end
    if (network_pc_event && !network_path_change_off) begin
      next_st.clr_n = 1'b1; // see R20
    end
    // A canceller that is out of service does not vote.
    next_st.fd_allow = (!acoustic_active || acoustic_ok) &&
                       (!network_active || network_ok); // see R21
  end

  // State register; reset loads the documented defaults.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st.thr      <= `EDCR_RST_THR;
      st.det      <= `EDCR_RST_DET;
      st.rdata    <= 16'h0000;
      st.clr_a    <= 1'b0;
      st.clr_n    <= 1'b0;
      st.frz_a    <= 1'b0;
      st.force_rx <= 1'b0;
      st.fd_allow <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs, all from flip-flops except network_echo_canceller, which also uses network_path_seen directly.
  always_comb begin
    reg_rdata               = st.rdata;
    full_duplex_allow       = st.fd_allow;
    clear_acoustic_coef     = st.clr_a;
    clear_network_coef      = st.clr_n;
    freeze_acoustic_coef    = st.frz_a;
    force_receive           = st.force_rx;
    acoustic_echo_canceller = !st.det[`EDCR_AEC_BIT]; // see R21
    network_echo_canceller  = !st.det[`EDCR_NEC_BIT] &&
      !((st.thr[`EDCR_NETWORK_NOISE_THRESHOLD_LSB+1:`EDCR_NETWORK_NOISE_THRESHOLD_LSB] == 2'h1 ||
         st.thr[`EDCR_NETWORK_NOISE_THRESHOLD_LSB+1:`EDCR_NETWORK_NOISE_THRESHOLD_LSB] == 2'h2) &&
        !network_path_seen); // see R21 R9
    acoustic_preemphasis_on = !st.det[`EDCR_APF_BIT]; // see R16
    network_preemphasis_on  = !st.det[`EDCR_NPF_BIT]; // see R16
    receive_gain_select =
      st.thr[`EDCR_RECEIVE_GAIN_SELECT_LSB+1:`EDCR_RECEIVE_GAIN_SELECT_LSB]; // see R11
    transmit_gain_select =
      st.thr[`EDCR_TRANSMIT_GAIN_SELECT_LSB+1:`EDCR_TRANSMIT_GAIN_SELECT_LSB]; // see R12
    acoustic_sidetone_level =
      st.det[`EDCR_ACOUSTIC_SIDETONE_LEVEL_LSB+1:`EDCR_ACOUSTIC_SIDETONE_LEVEL_LSB]; // see R18
    network_sidetone_level =
      st.det[`EDCR_NETWORK_SIDETONE_LEVEL_LSB+1:`EDCR_NETWORK_SIDETONE_LEVEL_LSB]; // see R18
  end

  // Checks on the bank's own behaviour.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // A matching write to the threshold register.
  sequence s_thr_write;
    reg_wr && reg_addr == `EDCR_ADDR_THR &&
      reg_wdata[3:0] == `EDCR_CODE_THR;
  endsequence

  // A read of the detector register.
  sequence s_det_read;
    reg_rd && reg_addr == `EDCR_ADDR_DET;
  endsequence

  a_thr_write_lands: assert property ( // see R22
    s_thr_write |=> st.thr == $past(reg_wdata))
    else $error("Threshold write did not land.");

  a_code_mismatch_held: assert property ( // see R22
    reg_wr && reg_addr == `EDCR_ADDR_THR &&
      reg_wdata[3:0] != `EDCR_CODE_THR |=> $stable(st.thr))
    else $error("Write with wrong code changed register.");

  a_det_read_once: assert property ( // see R22
    s_det_read ##1 !reg_rd |=> reg_rdata == 16'h0000)
    else $error("Read data stood longer than one cycle.");

  a_det_read_value: assert property ( // see R22
    s_det_read |=> reg_rdata == $past(st.det))
    else $error("Read data differ from register.");

  a_howl_clears: assert property ( // see R13
    howl_event && !howl_detect_off |=>
      clear_acoustic_coef && clear_network_coef)
    else $error("Howl did not clear both cancellers.");

  a_howl_off_quiet: assert property ( // see R14
    howl_event && howl_detect_off && !network_pc_event |=>
      !clear_network_coef)
    else $error("Disabled howl detector cleared network.");

  a_tone_half_duplex: assert property ( // see R19
    tone_event && !tone_detect_off && !in_full_duplex |=>
      clear_acoustic_coef && force_receive && !freeze_acoustic_coef)
    else $error("Tone in half-duplex not handled.");

  a_tone_full_duplex: assert property ( // see R19
    tone_event && !tone_detect_off && in_full_duplex |=>
      freeze_acoustic_coef && !force_receive)
    else $error("Tone in full-duplex not handled.");

  a_net_path_change: assert property ( // see R20
    network_pc_event && !network_path_change_off |=>
      clear_network_coef)
    else $error("Network path change did not clear.");

  a_net_auto_off: assert property ( // see R9
    network_noise_threshold != 2'h0 && network_noise_threshold !=
      2'h3 && !network_path_seen |-> !network_echo_canceller)
    else $error("Network canceller not auto-disabled.");

  a_acoustic_erle_only: assert property ( // see R4
    acoustic_noise_threshold == 2'h0 && !acoustic_canceller_off &&
      acoustic_erle <= acoustic_erle_db |=> !full_duplex_allow)
    else $error("Duplex allowed below acoustic threshold.");

  // The checks below guard paths that tests reach in few cycles.

  // A matching write to the detector register.
  sequence s_det_write;
    reg_wr && reg_addr == `EDCR_ADDR_DET &&
      reg_wdata[3:0] == `EDCR_CODE_DET;
  endsequence

  a_det_write_lands: assert property ( // see R22
    s_det_write |=> st.det == $past(reg_wdata))
    else $error("Detector write did not land.");

  // Outside a read the data bus must rest at zero.
  a_read_idle_zero: assert property ( // see R22
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("Read data not zero while idle.");

  a_acoustic_pc_clears: assert property ( // see R20
    acoustic_pc_event && !acoustic_path_change_off |=>
      clear_acoustic_coef)
    else $error("Acoustic path change did not clear.");

  // Freeze and forced receive come only from the tone detector.
  a_tone_off_quiet: assert property ( // see R15
    tone_event && tone_detect_off |=>
      !freeze_acoustic_coef && !force_receive)
    else $error("Disabled tone detector acted.");

  // With a noise threshold set and a noisy input, enhancement alone
  // decides; the acoustic side asks for at least the threshold.
  a_acoustic_noisy_erle: assert property ( // see R3
    acoustic_noise_db != 8'h00 && near_noise < acoustic_noise_db &&
      acoustic_active && acoustic_erle < acoustic_erle_db |=>
      !full_duplex_allow)
    else $error("Noisy acoustic side allowed duplex.");

  a_net_noisy_erle: assert property ( // see R7
    network_noise_db != 8'h00 && far_noise < network_noise_db &&
      network_active && network_erle <= network_erle_db |=>
      !full_duplex_allow)
    else $error("Noisy network side allowed duplex.");

  a_net_erle_only: assert property ( // see R8
    network_noise_threshold == 2'h0 && !network_canceller_off &&
      network_erle <= network_erle_db |=> !full_duplex_allow)
    else $error("Duplex allowed below network threshold.");

  // With both cancellers out nothing votes, so duplex is granted with
  // no echo check at all; a user must know this limitation.
  a_both_off_allow: assert property ( // see R21
    acoustic_canceller_off && !network_active |=> full_duplex_allow)
    else $error("Idle cancellers still blocked duplex.");

endmodule : edcr_regs
`default_nettype wire

// File: test/edcr_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "edcr_defs.svh"

// Host controller model that writes and reads control words on the bus.
module edcr_host (
  input  wire logic        clk_sys,   // System clock.
  output logic      [3:0]  reg_addr,  // Register address.
  output logic      [15:0] reg_wdata, // Control word.
  output logic             reg_wr,    // Write strobe.
  output logic             reg_rd,    // Read strobe.
  input  wire logic [15:0] reg_rdata  // Read data from the bank.
);
  // The bus starts idle with both strobes low.
  initial begin
    reg_addr  = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // One raw write cycle. The idle bus then shows inverted values, so a
  // bank that samples outside its strobe sees junk, not the last word.
  task automatic wr_raw(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr_raw

  // A proper word always carries its register's select code in bits 3:0.
  task automatic wr_word(input logic [3:0] a, input logic [11:0] f);
    logic [3:0] code;
    code = (a == `EDCR_ADDR_THR) ? `EDCR_CODE_THR : `EDCR_CODE_DET;
    wr_raw(a, {f, code});
  endtask : wr_word

  // One read cycle; the data stand only in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask : rd

  // Bring-up word for a system whose network path is unknown: the
  // network noise threshold is set nonzero, at -42 dB.
  task automatic bring_up;
    wr_word(`EDCR_ADDR_THR, 12'h010);
  endtask : bring_up
endmodule : edcr_host
`default_nettype wire

// File: test/echo_duplex_control_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "edcr_defs.svh"

module echo_duplex_control_regs_tb;
  typedef struct packed {
    logic [3:0]  a;  // Address.
    logic [15:0] w;  // Raw word.
    logic        ok; // Word should be taken.
  } edcr_row_t;

  logic        clk_sys = 1'b0;  // System clock.
  logic        rst     = 1'b1;  // Reset, high at start.
  logic [3:0]  reg_addr;        // Host address.
  logic [15:0] reg_wdata;       // Host word.
  logic        reg_wr;          // Host write strobe.
  logic        reg_rd;          // Host read strobe.
  logic [15:0] reg_rdata;       // Read data.
  logic [7:0]  acoustic_erle = 8'h00, network_erle = 8'h00; // Measures.
  logic [7:0]  near_noise = 8'h00, far_noise = 8'h00; // Noise levels.
  logic        acoustic_asym_ok = 1'b0, network_asym_ok = 1'b0; // Estimates.
  logic        network_path_seen = 1'b1; // Path present by default.
  logic        in_full_duplex = 1'b0; // Engine mode.
  logic        howl_event = 1'b0, tone_event = 1'b0; // Event pulses.
  logic        acoustic_pc_event = 1'b0, network_pc_event = 1'b0;
  logic        full_duplex_allow, clear_acoustic_coef, clear_network_coef;
  logic        freeze_acoustic_coef, force_receive;
  logic        acoustic_echo_canceller, network_echo_canceller;
  logic        acoustic_preemphasis_on, network_preemphasis_on;
  logic [1:0]  receive_gain_select, transmit_gain_select;
  logic [1:0]  acoustic_sidetone_level, network_sidetone_level;
  logic [15:0] s4, s5, d;       // Expected contents and read word.
  int          fail_count = 0;  // Mismatches.
  int          total_checks = 0; // Comparisons.
  // Every gain, sidetone and disable code, plus refused words.
  edcr_row_t   rows [11] = '{
    '{4'h4, 16'h5558, 1'b1}, '{4'h4, 16'hAAA8, 1'b1},
    '{4'h4, 16'hFFF8, 1'b1}, '{4'h4, 16'h00F9, 1'b0},
    '{4'h5, 16'hFFFA, 1'b1}, '{4'h5, 16'h555A, 1'b1},
    '{4'h5, 16'hAAAA, 1'b1}, '{4'h5, 16'h0008, 1'b0},
    '{4'h6, 16'h1238, 1'b0}, '{4'h5, 16'h000A, 1'b1},
    '{4'h4, 16'h0008, 1'b1}};

  edcr_regs uut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .acoustic_erle, .network_erle, .near_noise, .far_noise,
    .acoustic_asym_ok, .network_asym_ok, .network_path_seen,
    .in_full_duplex, .howl_event, .tone_event, .acoustic_pc_event,
    .network_pc_event, .full_duplex_allow, .clear_acoustic_coef,
    .clear_network_coef, .freeze_acoustic_coef, .force_receive,
    .acoustic_echo_canceller, .network_echo_canceller,
    .acoustic_preemphasis_on, .network_preemphasis_on,
    .receive_gain_select, .transmit_gain_select,
    .acoustic_sidetone_level, .network_sidetone_level);
  edcr_host host (.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata);

  // The clock toggles every half period of 25 ns.
  always #25 clk_sys = ~clk_sys;

  // Compares two words and reports a mismatch at once.
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_word

  // Compares one flag; widened so an unknown cannot pass.
  task automatic cmp_flag(input logic got, input logic exp);
    cmp_word({15'h0000, got}, {15'h0000, exp});
  endtask : cmp_flag

  // Reads both registers back and checks the fields they drive.
  task automatic chk_regs;
    host.rd(`EDCR_ADDR_THR, d);
    cmp_word(d, s4);
    host.rd(`EDCR_ADDR_DET, d);
    cmp_word(d, s5);
    cmp_word({receive_gain_select, transmit_gain_select,
      acoustic_sidetone_level, network_sidetone_level,
      acoustic_preemphasis_on, network_preemphasis_on,
      acoustic_echo_canceller, network_echo_canceller, 4'h0},
      {s4[7:4], s5[7:4], ~s5[11:8], 4'h0});
  endtask : chk_regs

  // Raises events for one cycle; pulses {clear a, clear n, freeze, force}
  // must stand in the next cycle only.
  task automatic ev_chk(input logic [3:0] e, input logic [3:0] exp);
    @(posedge clk_sys);
    {howl_event, tone_event, acoustic_pc_event, network_pc_event} <= e;
    @(posedge clk_sys);
    {howl_event, tone_event, acoustic_pc_event, network_pc_event} <= 4'h0;
    #1 cmp_word({12'h000, clear_acoustic_coef, clear_network_coef,
      freeze_acoustic_coef, force_receive}, {12'h000, exp});
    @(posedge clk_sys);
    #1 cmp_word({12'h000, clear_acoustic_coef, clear_network_coef,
      freeze_acoustic_coef, force_receive}, 16'h0000);
  endtask : ev_chk

  // Sets measures {a erle, n erle, near, far} and flags {a ok, n ok,
  // path}, then checks the registered duplex permission.
  task automatic dec(input logic [31:0] v, input logic [2:0] f,
                     input logic exp);
    @(posedge clk_sys);
    {acoustic_erle, network_erle, near_noise, far_noise} <= v;
    {acoustic_asym_ok, network_asym_ok, network_path_seen} <= f;
    repeat (2) @(posedge clk_sys);
    #1 cmp_flag(full_duplex_allow, exp);
  endtask : dec

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  // Watchdog: the whole sequence needs well under 2000 cycles.
  initial begin
    #(2000 * 50);
    fail_count++;
    conclude;
  end

  // Main sequence.
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    s4 = `EDCR_RST_THR;
    s5 = `EDCR_RST_DET;
    chk_regs;
    $display("reset values done");
    foreach (rows[i]) begin
      host.wr_raw(rows[i].a, rows[i].w);
      if (rows[i].ok && rows[i].a == `EDCR_ADDR_THR) s4 = rows[i].w;
      if (rows[i].ok && rows[i].a == `EDCR_ADDR_DET) s5 = rows[i].w;
      chk_regs;
      $display("row %0d done", i);
    end
    host.rd(4'h6, d);
    cmp_word(d, 16'h0000);
    ev_chk(4'h8, 4'hC);
    ev_chk(4'h4, 4'h9);
    ev_chk(4'h2, 4'h8);
    ev_chk(4'h1, 4'h4);
    @(posedge clk_sys);
    in_full_duplex <= 1'b1;
    ev_chk(4'h4, 4'h2);
    host.wr_word(`EDCR_ADDR_DET, 12'hF00);
    ev_chk(4'hF, 4'h0);
    host.wr_word(`EDCR_ADDR_DET, 12'h000);
    $display("events done");
    dec(32'h1919_0000, 3'b001, 1'b1);
    dec(32'h1819_0000, 3'b111, 1'b0);
    dec(32'h1918_0000, 3'b111, 1'b0);
    host.wr_word(`EDCR_ADDR_THR, 12'h5A0);
    dec(32'h121F_2832, 3'b001, 1'b1);
    dec(32'h111F_2832, 3'b111, 1'b0);
    dec(32'h121E_2832, 3'b111, 1'b0);
    dec(32'h001F_3232, 3'b101, 1'b1);
    dec(32'h001F_3232, 3'b001, 1'b0);
    dec(32'h1200_283C, 3'b011, 1'b1);
    dec(32'h1200_283C, 3'b001, 1'b0);
    dec(32'h1200_283C, 3'b000, 1'b1);
    cmp_flag(network_echo_canceller, 1'b0);
    host.wr_word(`EDCR_ADDR_DET, 12'h020);
    dec(32'h001F_2832, 3'b001, 1'b1);
    cmp_flag(acoustic_echo_canceller, 1'b0);
    @(posedge clk_sys);
    network_path_seen <= 1'b0;
    host.bring_up;
    #1 cmp_flag(network_echo_canceller, 1'b0);
    $display("decision done");
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    s4 = `EDCR_RST_THR;
    s5 = `EDCR_RST_DET;
    network_path_seen <= 1'b1;
    chk_regs;
    $display("second reset done");
    conclude;
  end
endmodule : echo_duplex_control_regs_tb
`default_nettype wire
